// ---- hw/pcxn_ctrl.sv ----
// Purpose: physical connection manager command and control
// Assumes: all inputs come from logic on CLOCK; CTRL_WR writes all fields, attach only in OFF, test select and join only when next_open
// Notes: fresh-write detection compares against the stored field value
`timescale 1ns/1ns
`default_nettype none
module pcxn_ctrl
#(
   parameter int STT_W = pcxn_pkg::STT_W,
   parameter int SCRUB_CYCLES = pcxn_pkg::SCRUB_CYCLES
)
(
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   // control write
   input wire logic CTRL_WR,
   input wire logic SINGLE_ATTACH_STATION,
   input wire logic [1:0] LINK_TEST_SELECT,
   input wire logic LONG_TEST,
   input wire logic JOIN_REQUEST,
   input wire logic MAINT_REQUEST,
   input wire logic [1:0] CONNECTION_COMMAND,
   input wire logic DATAPATH_OVERRIDE,
   input wire logic SCRUB_REQUEST,
   input wire logic CORE_BYPASS_SELECT,
   input wire logic REMOTE_LOOP_ENABLE,
   input wire logic [STT_W-1:0] SHORT_TEST_TIME,
   input wire logic SIGNAL_CMD,
   // connection manager events
   input wire logic SIGNALING_ACTIVE,
   input wire logic CONNECT_DONE,
   input wire logic JOIN_DONE,
   input wire logic TIMEOUT,
   input wire logic QUIET_LINE_STATE,
   input wire logic MASTER_LINE_STATE,
   input wire logic HALT_LINE_STATE,
   // symbol data
   input wire logic [pcxn_pkg::SYM_W-1:0] RECEIVE_SYMBOL_DATA,
   input wire logic [pcxn_pkg::SYM_W-1:0] MAC_TRANSMIT_DATA,
   output logic [pcxn_pkg::SYM_W-1:0] REPEAT_OUTPUT_DATA,
   // status
   output logic [2:0] CONN_STATE,
   output logic SINGLE_ATTACH_STATE,
   output logic TEST_DONE_FLAG,
   output logic LINK_TEST_RUNNING,
   output logic [1:0] TX_LINE_SOURCE,
   output logic BYPASS_ACTIVE,
   output logic SCRUB_ACTIVE,
   output logic REMOTE_LOOP_ACTIVE
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   // scrub count constants at counter width
   localparam logic [31:0] SCRUB_WIDE = 32'(SCRUB_CYCLES);
   localparam logic [pcxn_pkg::SCRUB_W-1:0] SCRUB_LOAD = SCRUB_WIDE[pcxn_pkg::SCRUB_W-1:0];
   localparam logic [pcxn_pkg::SCRUB_W-1:0] SCRUB_ONE = {{(pcxn_pkg::SCRUB_W-1){1'b0}}, 1'b1};
   // connection manager state
   pcxn_pkg::pcxn_state_type state_reg;
   pcxn_pkg::pcxn_state_type state_next;
   logic armed_reg; // start seen, may leave BREAK
   logic armed_next;
   logic [pcxn_pkg::SCRUB_W-1:0] scrub_cnt_reg;
   logic [pcxn_pkg::SCRUB_W-1:0] scrub_cnt_next;
   // stored control fields
   logic sas_reg;
   logic sas_next;
   logic [1:0] lts_reg;
   logic [1:0] lts_next;
   logic long_reg;
   logic long_next;
   logic join_reg;
   logic join_next;
   logic maint_reg;
   logic maint_next;
   logic [1:0] cmd_reg;
   logic [1:0] cmd_next;
   logic ovr_reg;
   logic ovr_next;
   logic scrub_req_reg;
   logic scrub_req_next;
   logic byp_sel_reg;
   logic byp_sel_next;
   logic rem_reg;
   logic rem_next;
   logic [STT_W-1:0] stt_reg;
   logic [STT_W-1:0] stt_next;
   // link test
   logic test_run_reg;
   logic test_run_next;
   logic test_done_reg;
   logic test_done_next;
   logic timer_load;
   logic timer_run;
   logic timer_done;
   // path selection and line source
   logic path_scrub_reg;
   logic path_scrub_next;
   logic path_bypass_reg;
   logic path_bypass_next;
   logic path_loop_reg;
   logic path_loop_next;
   logic [1:0] tx_src_reg;
   logic [1:0] tx_src_next;
   // write events
   logic next_open;
   logic cmd_fire;
   logic join_fire;
   logic lts_fire;
   logic test_stop;
   // symbol path
   logic [pcxn_pkg::SYM_W-1:0] repeat_sym;
   pcxn_dp_if dp_bus ();

   // ----------------------------------------------------------------
   // write events
   // ----------------------------------------------------------------
   // a code acts only when written nonzero over a cleared value
   function automatic logic fresh_code(input logic [1:0] old_val, input logic [1:0] new_val);
      fresh_code = (old_val == 2'h0) && (new_val != 2'h0);
   endfunction

   // test select and join are open only in NEXT with signaling idle
   assign next_open = (state_reg == pcxn_pkg::PCXN_NEXT) && !SIGNALING_ACTIVE;
   assign cmd_fire = CTRL_WR && fresh_code(cmd_reg, CONNECTION_COMMAND);
   assign join_fire = CTRL_WR && next_open && fresh_code({1'b0, join_reg}, {1'b0, JOIN_REQUEST});
   assign lts_fire = CTRL_WR && next_open && fresh_code(lts_reg, LINK_TEST_SELECT);

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   // field capture on the write strobe
   always_comb
   begin
      sas_next = sas_reg;
      lts_next = lts_reg;
      long_next = long_reg;
      join_next = join_reg;
      maint_next = maint_reg;
      cmd_next = cmd_reg;
      ovr_next = ovr_reg;
      scrub_req_next = scrub_req_reg;
      byp_sel_next = byp_sel_reg;
      rem_next = rem_reg;
      stt_next = stt_reg;
      if (CTRL_WR)
      begin
         long_next = LONG_TEST;
         maint_next = MAINT_REQUEST;
         cmd_next = CONNECTION_COMMAND;
         ovr_next = DATAPATH_OVERRIDE;
         scrub_req_next = SCRUB_REQUEST;
         byp_sel_next = CORE_BYPASS_SELECT;
         rem_next = REMOTE_LOOP_ENABLE;
         stt_next = SHORT_TEST_TIME;
         if (state_reg == pcxn_pkg::PCXN_OFF)
            sas_next = SINGLE_ATTACH_STATION;
         if (next_open)
         begin
            lts_next = LINK_TEST_SELECT;
            join_next = JOIN_REQUEST;
         end
      end
   end

   // field registers, all cleared by reset
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         sas_reg <= 1'b0;
         lts_reg <= 2'h0;
         long_reg <= 1'b0;
         join_reg <= 1'b0;
         maint_reg <= 1'b0;
         cmd_reg <= 2'h0;
         ovr_reg <= 1'b0;
         scrub_req_reg <= 1'b0;
         byp_sel_reg <= 1'b0;
         rem_reg <= 1'b0;
         stt_reg <= '0;
      end
      else if (CE)
      begin
         sas_reg <= sas_next;
         lts_reg <= lts_next;
         long_reg <= long_next;
         join_reg <= join_next;
         maint_reg <= maint_next;
         cmd_reg <= cmd_next;
         ovr_reg <= ovr_next;
         scrub_req_reg <= scrub_req_next;
         byp_sel_reg <= byp_sel_next;
         rem_reg <= rem_next;
         stt_reg <= stt_next;
      end
   end

   // ----------------------------------------------------------------
   // connection state machine
   // ----------------------------------------------------------------
   // next state from handshakes, line events and commands
   always_comb
   begin
      state_next = state_reg;
      armed_next = armed_reg;
      scrub_cnt_next = scrub_cnt_reg;
      case (state_reg)
         pcxn_pkg::PCXN_OFF:
         begin
            if (maint_reg)
               state_next = pcxn_pkg::PCXN_MAINT;
         end
         pcxn_pkg::PCXN_BREAK:
         begin
            if (scrub_cnt_reg != '0)
               scrub_cnt_next = scrub_cnt_reg - SCRUB_ONE;
            else if (armed_reg)
            begin
               state_next = pcxn_pkg::PCXN_CONNECT;
               armed_next = 1'b0;
            end
         end
         pcxn_pkg::PCXN_CONNECT:
         begin
            if (CONNECT_DONE)
               state_next = pcxn_pkg::PCXN_NEXT;
         end
         pcxn_pkg::PCXN_NEXT:
         begin
            if (join_fire)
               state_next = pcxn_pkg::PCXN_JOIN;
         end
         pcxn_pkg::PCXN_JOIN:
         begin
            if (JOIN_DONE)
               state_next = pcxn_pkg::PCXN_ACTIVE;
         end
         default:
         begin
            state_next = state_reg;
         end
      endcase
      // line events break the connection without arming a restart
      if ((QUIET_LINE_STATE || TIMEOUT) && state_reg != pcxn_pkg::PCXN_OFF &&
         state_reg != pcxn_pkg::PCXN_MAINT && state_reg != pcxn_pkg::PCXN_BREAK)
      begin
         state_next = pcxn_pkg::PCXN_BREAK;
         armed_next = 1'b0;
         if (state_reg == pcxn_pkg::PCXN_ACTIVE)
            scrub_cnt_next = SCRUB_LOAD;
      end
      // commands override everything else
      if (cmd_fire)
      begin
         if (CONNECTION_COMMAND == pcxn_pkg::CMD_START)
         begin
            armed_next = 1'b1;
            if (state_reg != pcxn_pkg::PCXN_BREAK)
            begin
               state_next = pcxn_pkg::PCXN_BREAK;
               if (state_reg == pcxn_pkg::PCXN_ACTIVE)
                  scrub_cnt_next = SCRUB_LOAD;
               else
                  scrub_cnt_next = '0;
            end
         end
         else if (CONNECTION_COMMAND == pcxn_pkg::CMD_STOP)
         begin
            state_next = pcxn_pkg::PCXN_OFF;
            armed_next = 1'b0;
            scrub_cnt_next = '0;
         end
         else if (CONNECTION_COMMAND == pcxn_pkg::CMD_TRACE && state_reg == pcxn_pkg::PCXN_ACTIVE)
            state_next = pcxn_pkg::PCXN_TRACE;
      end
   end

   // state registers
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         state_reg <= pcxn_pkg::PCXN_OFF;
         armed_reg <= 1'b0;
         scrub_cnt_reg <= '0;
      end
      else if (CE)
      begin
         state_reg <= state_next;
         armed_reg <= armed_next;
         scrub_cnt_reg <= scrub_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // link confidence test
   // ----------------------------------------------------------------
   // stop on line state, signal, timer, join or command
   assign test_stop = test_run_reg && (MASTER_LINE_STATE || HALT_LINE_STATE || SIGNAL_CMD ||
      (!long_reg && timer_done) || join_fire || cmd_fire);
   assign timer_run = test_run_reg && !long_reg;

   // start, stop and done flag
   always_comb
   begin
      test_run_next = test_run_reg;
      test_done_next = test_done_reg;
      timer_load = 1'b0;
      if (test_stop)
         test_run_next = 1'b0;
      if (lts_fire && !join_fire && !cmd_fire)
      begin
         test_run_next = 1'b1;
         test_done_next = 1'b1;
         timer_load = 1'b1;
      end
      if (state_next != pcxn_pkg::PCXN_NEXT)
         test_run_next = 1'b0;
      if (state_next == pcxn_pkg::PCXN_BREAK || state_next == pcxn_pkg::PCXN_OFF)
         test_done_next = 1'b0;
   end

   // test registers
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         test_run_reg <= 1'b0;
         test_done_reg <= 1'b0;
      end
      else if (CE)
      begin
         test_run_reg <= test_run_next;
         test_done_reg <= test_done_next;
      end
   end

   // short test timer
   pcxn_lct_timer #(.W(STT_W)) i_pcxn_lct_timer (.clk(CLOCK), .rst(RST), .ce(CE), .load(timer_load),
      .run(timer_run), .length(stt_reg), .done(timer_done));

   // ----------------------------------------------------------------
   // data path selection
   // ----------------------------------------------------------------
   // from next values so the path moves with the state
   always_comb
   begin
      path_scrub_next = 1'b0;
      path_bypass_next = 1'b0;
      path_loop_next = 1'b0;
      tx_src_next = pcxn_pkg::TX_QUIET;
      if (state_next == pcxn_pkg::PCXN_MAINT || ovr_next)
      begin
         path_scrub_next = scrub_req_next;
         path_bypass_next = byp_sel_next;
         path_loop_next = rem_next;
      end
      else
      begin
         path_scrub_next = (state_next == pcxn_pkg::PCXN_BREAK) && (scrub_cnt_next != '0);
         path_bypass_next = !sas_next && state_next != pcxn_pkg::PCXN_ACTIVE &&
            state_next != pcxn_pkg::PCXN_TRACE;
         path_loop_next = test_run_next && (lts_next == pcxn_pkg::LCT_PHY_LOOP);
      end
      if (test_run_next)
         tx_src_next = (lts_next == pcxn_pkg::LCT_IDLE) ? pcxn_pkg::TX_IDLE : pcxn_pkg::TX_PHY_DATA;
      else if (state_next == pcxn_pkg::PCXN_ACTIVE || state_next == pcxn_pkg::PCXN_TRACE)
         tx_src_next = pcxn_pkg::TX_PHY_DATA;
      else if (state_next != pcxn_pkg::PCXN_OFF)
         tx_src_next = pcxn_pkg::TX_IDLE;
   end

   // path registers; bypass starts set to match OFF
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         path_scrub_reg <= 1'b0;
         path_bypass_reg <= 1'b1;
         path_loop_reg <= 1'b0;
         tx_src_reg <= pcxn_pkg::TX_QUIET;
      end
      else if (CE)
      begin
         path_scrub_reg <= path_scrub_next;
         path_bypass_reg <= path_bypass_next;
         path_loop_reg <= path_loop_next;
         tx_src_reg <= tx_src_next;
      end
   end

   // selection to the symbol path
   assign dp_bus.scrub = path_scrub_reg;
   assign dp_bus.bypass = path_bypass_reg;
   assign dp_bus.remote_loop_enable = path_loop_reg;

   // repeat multiplexer
   pcxn_datapath i_pcxn_datapath (.clk(CLOCK), .rst(RST), .ce(CE), .sel(dp_bus.dp),
      .rx_sym(RECEIVE_SYMBOL_DATA), .tx_sym(MAC_TRANSMIT_DATA), .repeat_sym(repeat_sym));

   // ----------------------------------------------------------------
   // outputs, all from registers
   // ----------------------------------------------------------------
   assign REPEAT_OUTPUT_DATA = repeat_sym;
   assign CONN_STATE = state_reg;
   assign SINGLE_ATTACH_STATE = sas_reg;
   assign TEST_DONE_FLAG = test_done_reg;
   assign LINK_TEST_RUNNING = test_run_reg;
   assign TX_LINE_SOURCE = tx_src_reg;
   assign BYPASS_ACTIVE = path_bypass_reg;
   assign SCRUB_ACTIVE = path_scrub_reg;
   assign REMOTE_LOOP_ACTIVE = path_loop_reg;
endmodule
`default_nettype wire

// ---- hw/pcxn_datapath.sv ----
// Purpose: repeat output multiplexer with one byte clock of latency
// Assumes: symbol inputs come from logic on the byte clock
// Notes: scrub beats bypass, bypass beats receive data
`timescale 1ns/1ns
`default_nettype none
module pcxn_datapath
(
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   pcxn_dp_if.dp sel,
   // symbols
   input wire logic [pcxn_pkg::SYM_W-1:0] rx_sym,
   input wire logic [pcxn_pkg::SYM_W-1:0] tx_sym,
   output logic [pcxn_pkg::SYM_W-1:0] repeat_sym
);
   logic [pcxn_pkg::SYM_W-1:0] rep_reg;
   logic [pcxn_pkg::SYM_W-1:0] rep_next;

   // source selection for the repeat path
   always_comb
   begin
      if (sel.scrub)
         rep_next = pcxn_pkg::IDLE_PAIR;
      else if (sel.bypass)
         rep_next = tx_sym;
      else
         rep_next = rx_sym;
   end

   // single latch stage
   always_ff @(posedge clk)
   begin
      if (rst)
         rep_reg <= pcxn_pkg::SYM_RESET;
      else if (ce)
         rep_reg <= rep_next;
   end

   assign repeat_sym = rep_reg;
endmodule
`default_nettype wire

// ---- hw/pcxn_dp_if.sv ----
// Purpose: path selection from control logic to symbol data path
// Assumes: single byte clock domain
// Notes: levels only, no handshake
`timescale 1ns/1ns
`default_nettype none
interface pcxn_dp_if;
   logic scrub;
   logic bypass;
   logic remote_loop_enable;
   modport ctl (output scrub, output bypass, output remote_loop_enable);
   modport dp (input scrub, input bypass, input remote_loop_enable);
endinterface
`default_nettype wire

// ---- hw/pcxn_lct_timer.sv ----
// Purpose: short link test down-counter
// Assumes: load and count on the byte clock
// Notes: done rises as the count reaches zero and stays high while run is held at zero count
`timescale 1ns/1ns
`default_nettype none
module pcxn_lct_timer
#(
   parameter int W = pcxn_pkg::STT_W
)
(
   // clock
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic load,
   input wire logic run,
   input wire logic [W-1:0] length,
   output logic done
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic done_reg;
   logic done_next;

   // count down while running
   always_comb
   begin
      cnt_next = cnt_reg;
      done_next = 1'b0;
      if (load)
         cnt_next = length;
      else if (run && cnt_reg != '0)
      begin
         cnt_next = cnt_reg - W'(1);
         done_next = (cnt_reg == W'(1));
      end
      else if (run)
         done_next = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end
      else if (ce)
      begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule
`default_nettype wire

// ---- hw/pcxn_pkg.sv ----
// Purpose: shared constants and types of the connection control block
// Assumes: 50 MHz byte clock
// Notes: shared codes, symbol reset values and counts live here
package pcxn_pkg;

   // ----------------------------------------------------------------
   // connection manager states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      PCXN_OFF     = 3'b000,
      PCXN_BREAK   = 3'b001,
      PCXN_CONNECT = 3'b010,
      PCXN_NEXT    = 3'b011,
      PCXN_JOIN    = 3'b100,
      PCXN_ACTIVE  = 3'b101,
      PCXN_TRACE   = 3'b110,
      PCXN_MAINT   = 3'b111
   } pcxn_state_type;

   // ----------------------------------------------------------------
   // command and test codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_START = 2'h1;
   localparam logic [1:0] CMD_TRACE = 2'h2;
   localparam logic [1:0] CMD_STOP = 2'h3;
   localparam logic [1:0] LCT_NONE = 2'h0;
   localparam logic [1:0] LCT_PHY_DATA = 2'h1;
   localparam logic [1:0] LCT_IDLE = 2'h2;
   localparam logic [1:0] LCT_PHY_LOOP = 2'h3;

   // transmit line source selection
   localparam logic [1:0] TX_QUIET = 2'h0;
   localparam logic [1:0] TX_IDLE = 2'h1;
   localparam logic [1:0] TX_PHY_DATA = 2'h2;

   // ----------------------------------------------------------------
   // data path and timing
   // ----------------------------------------------------------------
   localparam int SYM_W = 10;
   localparam logic [SYM_W-1:0] IDLE_PAIR = 10'h3FF;
   localparam logic [SYM_W-1:0] SYM_RESET = 10'h000;
   localparam int CLOCK_MHZ = 50;
   localparam int SCRUB_TIME_NS = 3500;
   localparam int SCRUB_CYCLES = (SCRUB_TIME_NS * CLOCK_MHZ + 999) / 1000;
   localparam int SCRUB_W = 12;
   localparam int STT_W = 16;
   localparam logic [2:0] STATE_RESET = 3'h0;

endpackage

// ---- tb/pcxn_ctrl_props.sv ----
// Purpose: state and path checks on the control block
// Assumes: path outputs settle with the state
// Notes: bound to every pcxn_ctrl
`timescale 1ns/1ns
`default_nettype none
module pcxn_ctrl_props
(
   // watched ports
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic DATAPATH_OVERRIDE,
   input wire logic [2:0] CONN_STATE,
   input wire logic SINGLE_ATTACH_STATE,
   input wire logic LINK_TEST_RUNNING,
   input wire logic BYPASS_ACTIVE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_sas; SINGLE_ATTACH_STATE && !DATAPATH_OVERRIDE && CONN_STATE != 3'h5 && CONN_STATE != 3'h7
      |-> !BYPASS_ACTIVE; endproperty
   a_sas: assert property (p_sas) else $error("bypass before active");
   property p_das; !SINGLE_ATTACH_STATE && !DATAPATH_OVERRIDE && CONN_STATE < 3'h5 |-> BYPASS_ACTIVE; endproperty
   a_das: assert property (p_das) else $error("no bypass");
   property p_hold; CONN_STATE != 3'h0 |=> $stable(SINGLE_ATTACH_STATE); endproperty
   a_hold: assert property (p_hold) else $error("flag changed");
   property p_join; CONN_STATE == 3'h4 && $past(CONN_STATE) != 3'h4 |-> $past(CONN_STATE) == 3'h3; endproperty
   a_join: assert property (p_join) else $error("join entry");
   property p_maint; CONN_STATE == 3'h7 && $past(CONN_STATE) != 3'h7 |-> $past(CONN_STATE) == 3'h0; endproperty
   a_maint: assert property (p_maint) else $error("maint entry");
   property p_trace; CONN_STATE == 3'h6 && $past(CONN_STATE) != 3'h6 |-> $past(CONN_STATE) == 3'h5; endproperty
   a_trace: assert property (p_trace) else $error("trace entry");
   property p_rst; $fell(RST) |-> CONN_STATE == 3'h0 && !SINGLE_ATTACH_STATE; endproperty
   a_rst: assert property (p_rst) else $error("reset values");
   property p_lct; LINK_TEST_RUNNING |-> CONN_STATE == 3'h3; endproperty
   a_lct: assert property (p_lct) else $error("test outside next");
endmodule
bind pcxn_ctrl pcxn_ctrl_props i_pcxn_ctrl_props (.CLOCK(CLOCK), .RST(RST), .DATAPATH_OVERRIDE(DATAPATH_OVERRIDE),
   .CONN_STATE(CONN_STATE), .SINGLE_ATTACH_STATE(SINGLE_ATTACH_STATE), .LINK_TEST_RUNNING(LINK_TEST_RUNNING),
   .BYPASS_ACTIVE(BYPASS_ACTIVE));
`default_nettype wire

// ---- tb/pcxn_ctrl_tb.sv ----
// Purpose: walk the connection manager through its commands
// Assumes: fields are taken on a one-cycle write strobe
// Notes: neighbour model closes connect and join
`timescale 1ns/1ns
`default_nettype none
module pcxn_ctrl_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic single_attach_station = 1'b0;
   logic jn = 1'b0;
   logic mt = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic [1:0] lts = 2'h0;
   logic lng = 1'b0;
   logic ovr = 1'b0;
   logic scr = 1'b0;
   logic byp = 1'b0;
   logic rem = 1'b0;
   logic qls = 1'b0;
   logic master_line_state = 1'b0;
   logic halt_line_state = 1'b0;
   logic [9:0] rxd = 10'h155;
   logic [9:0] txd = 10'h2AA;
   logic [2:0] st;
   logic sas_q;
   logic cd;
   logic jd;
   logic [9:0] rep;
   logic tdf;
   logic ltr;
   logic [1:0] txs;
   logic byq;
   logic scq;
   logic rlq;
   int mismatches = 0;
   int checks_done = 0;
   // 50 MHz clock
   always #10 clk = ~clk;
   pcxn_nbr i_pcxn_nbr (.clk(clk), .state(st), .conn_done(cd), .join_done(jd));
   pcxn_ctrl i_pcxn_ctrl (.CLOCK(clk), .RST(rst), .CE(1'b1), .CTRL_WR(wr), .SINGLE_ATTACH_STATION(single_attach_station),
      .LINK_TEST_SELECT(lts), .LONG_TEST(lng), .JOIN_REQUEST(jn), .MAINT_REQUEST(mt), .CONNECTION_COMMAND(cmd),
      .DATAPATH_OVERRIDE(ovr), .SCRUB_REQUEST(scr), .CORE_BYPASS_SELECT(byp), .REMOTE_LOOP_ENABLE(rem),
      .SHORT_TEST_TIME(16'h0010), .SIGNAL_CMD(1'b0), .SIGNALING_ACTIVE(1'b0), .CONNECT_DONE(cd), .JOIN_DONE(jd),
      .TIMEOUT(1'b0), .QUIET_LINE_STATE(qls), .MASTER_LINE_STATE(master_line_state), .HALT_LINE_STATE(halt_line_state),
      .RECEIVE_SYMBOL_DATA(rxd), .MAC_TRANSMIT_DATA(txd), .REPEAT_OUTPUT_DATA(rep), .CONN_STATE(st),
      .SINGLE_ATTACH_STATE(sas_q), .TEST_DONE_FLAG(tdf), .LINK_TEST_RUNNING(ltr), .TX_LINE_SOURCE(txs),
      .BYPASS_ACTIVE(byq), .SCRUB_ACTIVE(scq), .REMOTE_LOOP_ACTIVE(rlq));
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one write strobe carrying all fields
   task automatic ctl(input logic [1:0] c, input logic j, input logic m, input logic s);
      @(posedge clk);
      cmd <= c;
      jn <= j;
      mt <= m;
      single_attach_station <= s;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task automatic conclude();
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      conclude();
   end
   // reset values
   task automatic t_reset();
      @(posedge clk);
      chk("state", pcxn_pkg::PCXN_OFF, st);
      chk("attach", 10'h000, sas_q);
      chk("bypass", 10'h001, byq);
   endtask
   // single attach bring-up to ACTIVE
   task automatic t_bringup();
      ctl(2'h2, 1'b0, 1'b0, 1'b1);
      chk("state", pcxn_pkg::PCXN_OFF, st);
      chk("attach", 10'h001, sas_q);
      ctl(2'h0, 1'b0, 1'b0, 1'b1);
      ctl(2'h1, 1'b0, 1'b0, 1'b1);
      chk("state", pcxn_pkg::PCXN_NEXT, st);
      chk("bypass", 10'h000, byq);
      ctl(2'h1, 1'b1, 1'b0, 1'b0);
      chk("state", pcxn_pkg::PCXN_ACTIVE, st);
      chk("attach", 10'h001, sas_q);
   endtask
   // trace then maintenance with path bits
   task automatic t_maint();
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      ctl(2'h2, 1'b0, 1'b0, 1'b0);
      chk("state", pcxn_pkg::PCXN_TRACE, st);
      ctl(2'h0, 1'b0, 1'b1, 1'b0);
      ctl(2'h3, 1'b0, 1'b1, 1'b0);
      chk("state", pcxn_pkg::PCXN_MAINT, st);
      @(posedge clk);
      byp <= 1'b1;
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      chk("bypass", 10'h001, byq);
      chk("repeat", txd, rep);
   endtask
   // link test, abort by master line state, then join
   task automatic t_link();
      ctl(2'h1, 1'b0, 1'b0, 1'b0);
      chk("state", pcxn_pkg::PCXN_NEXT, st);
      @(posedge clk);
      lts <= 2'h3;
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      chk("running", 10'h001, ltr);
      chk("done flag", 10'h001, tdf);
      chk("remote loop", 10'h001, rlq);
      chk("line source", pcxn_pkg::TX_PHY_DATA, txs);
      @(posedge clk);
      master_line_state <= 1'b1;
      repeat (2) @(posedge clk);
      chk("running", 10'h000, ltr);
      master_line_state <= 1'b0;
      lts <= 2'h0;
      ctl(2'h0, 1'b1, 1'b0, 1'b0);
      chk("state", pcxn_pkg::PCXN_ACTIVE, st);
   endtask
   // restart from ACTIVE scrubs first
   task automatic t_scrub();
      ctl(2'h1, 1'b0, 1'b0, 1'b0);
      chk("state", pcxn_pkg::PCXN_BREAK, st);
      chk("scrub", 10'h001, scq);
      chk("repeat", pcxn_pkg::IDLE_PAIR, rep);
      repeat (200) @(posedge clk);
      chk("state", pcxn_pkg::PCXN_NEXT, st);
   endtask
   // dual attach in OFF, then override
   task automatic t_dual();
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      ctl(2'h3, 1'b0, 1'b0, 1'b0);
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      chk("attach", 10'h000, sas_q);
      chk("bypass", 10'h001, byq);
      chk("repeat", txd, rep);
      @(posedge clk);
      ovr <= 1'b1;
      scr <= 1'b1;
      ctl(2'h0, 1'b0, 1'b0, 1'b0);
      chk("scrub", 10'h001, scq);
      chk("repeat", pcxn_pkg::IDLE_PAIR, rep);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_bringup();
      t_maint();
      t_link();
      t_scrub();
      t_dual();
      conclude();
   end
endmodule
`default_nettype wire

// ---- tb/pcxn_nbr.sv ----
// Purpose: neighbour connection manager model
// Assumes: one clock shared with the block
// Notes: answers four cycles after each handshake state
`timescale 1ns/1ns
`default_nettype none
module pcxn_nbr
(
   // clock and observed state
   input wire logic clk,
   input wire logic [2:0] state,
   // answers
   output logic conn_done,
   output logic join_done
);
   logic [2:0] cnt_reg = 3'h0;
   // count time spent in a handshake state
   always_ff @(posedge clk)
   begin
      cnt_reg <= (state == pcxn_pkg::PCXN_CONNECT || state == pcxn_pkg::PCXN_JOIN) ? cnt_reg + 3'h1 : 3'h0;
   end
   assign conn_done = (state == pcxn_pkg::PCXN_CONNECT) && (cnt_reg == 3'h4);
   assign join_done = (state == pcxn_pkg::PCXN_JOIN) && (cnt_reg == 3'h4);
endmodule
`default_nettype wire
